// [common/wgr_defs.svh]
`ifndef WGR_DEFS_SVH
`define WGR_DEFS_SVH

// ****************************************
// Register word indices
// ****************************************
`define WGR_IDX_CMD        3'h0
`define WGR_IDX_OFFSET     3'h1
`define WGR_IDX_SPEED      3'h2
`define WGR_IDX_ACCEL      3'h3
`define WGR_IDX_PAGE       3'h4

// ****************************************
// Field positions and values
// ****************************************
`define WGR_CMD_REMOTE     8
`define WGR_CMD_AUTO       9
`define WGR_CMD_CENTER     12
`define WGR_CMD_OFS_EN     13
`define WGR_CMD_GP_RESET   14
`define WGR_CMD_REV_POL    15
`define WGR_SPD_EN         15
`define WGR_SPD_MSB        14
`define WGR_SPD_LSB        8
`define WGR_ACC_EN         7
`define WGR_PARAM_MAX      7'h64
`define WGR_PAGE_DEFAULT   16'h0000
`define WGR_PAGE_WEB       16'h0001
`define WGR_REG_RESET      16'h0000

// ****************************************
// Scaling and timing
// ****************************************
`define WGR_LSB_NM         63500
`define WGR_MARGIN_NM      3175000
`define WGR_MARGIN_CNT     16'((`WGR_MARGIN_NM + `WGR_LSB_NM - 1) / `WGR_LSB_NM)
`define WGR_CLK_HZ         20000000
`define WGR_GPR_TIMEOUT_MS 5000
`define WGR_GPR_TIMEOUT_CYC (`WGR_GPR_TIMEOUT_MS * (`WGR_CLK_HZ / 1000))
`endif

// [common/wgr_pkg.sv]
package wgr_pkg;
  // Guide-point reset timer states
  typedef enum logic [0:0] {WGR_TMR_IDLE, WGR_TMR_ARMED} wgr_tmr_state_t;

  typedef struct packed {
    wgr_tmr_state_t state;
    logic [31:0]    cnt;
    logic           accept;
    logic           reject;
  } wgr_tmr_st_t;

  typedef struct packed {
    logic signed [15:0] gp;
    logic signed [31:0] gp_nm;
  } wgr_gp_st_t;

  typedef struct packed {
    logic [15:0]        cmd;
    logic [15:0]        offset;
    logic [15:0]        speed_reg;
    logic [15:0]        accel_reg;
    logic [15:0]        page;
    logic [6:0]         speed;
    logic [6:0]         accel;
    logic               rev_pol;
    logic               web_map;
    logic [1:0]         page_flags;
    logic               center;
    logic               gp_ld;
    logic signed [15:0] gp_tgt;
    logic               gpr_start;
    logic               gpr_release;
    logic               gpr_abort;
    logic [15:0]        rd_data;
  } wgr_main_st_t;
endpackage

// [src/wgr_gp_calc.sv]
`timescale 1ns/1ps
`include "wgr_defs.svh"
module wgr_gp_calc (
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_ce,
  // Load request
  input  wire logic               i_load,
  input  wire logic signed [15:0] i_target,
  input  wire logic        [15:0] i_win_half,
  // Guide point
  output logic signed      [15:0] o_gp,
  output logic signed      [31:0] o_gp_nm
);
  wgr_pkg::wgr_gp_st_t st_ff;
  wgr_pkg::wgr_gp_st_t nxt_st;
  logic signed [16:0]  lim;
  logic signed [16:0]  tgt;
  logic signed [16:0]  clp;
  logic signed [47:0]  prod;

  // Clamp the target inside the window less the travel margin
  always_comb begin
    lim = $signed({1'b0, i_win_half}) - $signed({1'b0, `WGR_MARGIN_CNT});
    if (lim < 17'sh0) begin
      lim = 17'sh0;
    end
    tgt = 17'(i_target);
    if (tgt > lim) begin
      clp = lim;
    end else if (tgt < -lim) begin
      clp = -lim;
    end else begin
      clp = tgt;
    end
    prod   = 48'(clp) * 48'sd63500; // Counts to nanometres
    nxt_st = st_ff;
    if (i_load) begin
      nxt_st.gp    = 16'(clp); // Signed distance from window centre
      nxt_st.gp_nm = 32'(prod);
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else if (i_ce) begin
      st_ff <= nxt_st;
    end
  end

  assign o_gp    = st_ff.gp;
  assign o_gp_nm = st_ff.gp_nm;

  a_gp_margin: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && i_load) |=> (17'(st_ff.gp) <= $past(lim) && 17'(st_ff.gp) >= -$past(lim)))
    else $error("Guide point outside margin");
endmodule

// [src/wgr_gpr_timer.sv]
`timescale 1ns/1ps
`include "wgr_defs.svh"
module wgr_gpr_timer #(
  parameter logic [31:0] TIMEOUT_CYC = `WGR_GPR_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  // Handshake events
  input  wire logic i_start,
  input  wire logic i_release,
  input  wire logic i_abort,
  // Outcome
  output logic      o_accept,
  output logic      o_reject,
  output logic      o_busy
);
  wgr_pkg::wgr_tmr_st_t st_ff;
  wgr_pkg::wgr_tmr_st_t nxt_st;

  // Arm on start, accept a release before timeout, reject otherwise
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.accept = 1'b0;
    nxt_st.reject = 1'b0;
    unique case (st_ff.state)
      wgr_pkg::WGR_TMR_IDLE: begin
        if (i_start) begin
          nxt_st.state = wgr_pkg::WGR_TMR_ARMED;
          nxt_st.cnt   = '0;
        end
      end
      wgr_pkg::WGR_TMR_ARMED: begin
        nxt_st.cnt = st_ff.cnt + 32'h1;
        if (i_abort || st_ff.cnt >= TIMEOUT_CYC - 32'h1) begin
          nxt_st.state  = wgr_pkg::WGR_TMR_IDLE;
          nxt_st.reject = 1'b1;
        end else if (i_release) begin
          nxt_st.state  = wgr_pkg::WGR_TMR_IDLE;
          nxt_st.accept = 1'b1;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else if (i_ce) begin
      st_ff <= nxt_st;
    end
  end

  assign o_accept = st_ff.accept;
  assign o_reject = st_ff.reject;
  assign o_busy   = (st_ff.state == wgr_pkg::WGR_TMR_ARMED);
endmodule

// [src/wgr_cmd_regs.sv]
`timescale 1ns/1ps
`include "wgr_defs.svh"
module wgr_cmd_regs #(
  parameter logic [31:0] GPR_TIMEOUT_CYC = `WGR_GPR_TIMEOUT_CYC
) (
  // Clock, reset, enable
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_ce,
  // Master word write port
  input  wire logic               i_wr_en,
  input  wire logic        [2:0]  i_wr_index,
  input  wire logic        [15:0] i_wr_data,
  // Master word read port
  input  wire logic        [2:0]  i_rd_index,
  output logic             [15:0] o_rd_data,
  // Local operator and process
  input  wire logic               i_local_rev_set,
  input  wire logic               i_local_rev_clr,
  input  wire logic signed [15:0] i_web_pos,
  input  wire logic        [15:0] i_win_half,
  // Control outputs
  output logic                    o_remote_ctrl,
  output logic                    o_auto_mode,
  output logic                    o_center_start,
  output logic                    o_rev_polarity,
  output logic signed      [15:0] o_guide_point,
  output logic signed      [31:0] o_guide_point_nm,
  output logic                    o_gpr_busy,
  output logic                    o_gpr_accept,
  output logic                    o_gpr_reject,
  output logic             [6:0]  o_speed,
  output logic             [6:0]  o_accel,
  // Output map selection
  output logic                    o_web_map,
  output logic             [1:0]  o_page_flags
);
  // ****************************************
  // State and decode
  // ****************************************
  wgr_pkg::wgr_main_st_t st_ff;
  wgr_pkg::wgr_main_st_t nxt_st;
  logic                  cmd_wr;
  logic                  ofs_wr;
  logic                  spd_wr;
  logic                  acc_wr;
  logic                  page_wr;
  logic                  rise_center;
  logic                  rise_gpr;
  logic                  fall_gpr;
  logic                  tmr_accept;
  logic                  tmr_reject;
  logic                  tmr_busy;

  // Word write strobe for one index, qualified by the write enable
  function automatic logic wr_hit(input logic en, input logic [2:0] idx, input logic [2:0] want);
    wr_hit = en && (idx == want);
  endfunction

  // Clamp a 7-bit parameter to its top value
  function automatic logic [6:0] sat_param(input logic [6:0] v);
    sat_param = (v > `WGR_PARAM_MAX) ? `WGR_PARAM_MAX : v;
  endfunction

  // Strobes per register
  assign cmd_wr  = wr_hit(i_wr_en, i_wr_index, `WGR_IDX_CMD);
  assign ofs_wr  = wr_hit(i_wr_en, i_wr_index, `WGR_IDX_OFFSET);
  assign spd_wr  = wr_hit(i_wr_en, i_wr_index, `WGR_IDX_SPEED);
  assign acc_wr  = wr_hit(i_wr_en, i_wr_index, `WGR_IDX_ACCEL);
  assign page_wr = wr_hit(i_wr_en, i_wr_index, `WGR_IDX_PAGE);

  // Trigger edges between successive command writes
  assign rise_center = cmd_wr && i_wr_data[`WGR_CMD_CENTER] && !st_ff.cmd[`WGR_CMD_CENTER];
  assign rise_gpr    = cmd_wr && i_wr_data[`WGR_CMD_GP_RESET] && !st_ff.cmd[`WGR_CMD_GP_RESET];
  assign fall_gpr    = cmd_wr && !i_wr_data[`WGR_CMD_GP_RESET] && st_ff.cmd[`WGR_CMD_GP_RESET];

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    nxt_st             = st_ff;
    nxt_st.center      = 1'b0;
    nxt_st.gp_ld       = 1'b0;
    nxt_st.gpr_start   = 1'b0;
    nxt_st.gpr_release = 1'b0;
    nxt_st.gpr_abort   = 1'b0;

    // Command word: mode, remote, polarity and triggers
    if (cmd_wr) begin
      nxt_st.cmd     = i_wr_data;
      nxt_st.rev_pol = i_wr_data[`WGR_CMD_REV_POL];
      if (rise_center) begin
        if (!i_wr_data[`WGR_CMD_AUTO]) begin
          nxt_st.center = 1'b1; // Manual mode centering
        end else begin
          nxt_st.gp_ld  = 1'b1; // Auto mode midpoint
          nxt_st.gp_tgt = 16'sh0;
        end
      end
      if (rise_gpr && !i_wr_data[`WGR_CMD_AUTO] && i_wr_data[`WGR_CMD_REMOTE]) begin
        nxt_st.gpr_start = 1'b1;
      end
      if (fall_gpr) begin
        if (!i_wr_data[`WGR_CMD_AUTO] && i_wr_data[`WGR_CMD_REMOTE]) begin
          nxt_st.gpr_release = 1'b1;
        end else begin
          nxt_st.gpr_abort = 1'b1; // Mode or control lost mid-routine
        end
      end else if (tmr_busy && (i_wr_data[`WGR_CMD_AUTO] || !i_wr_data[`WGR_CMD_REMOTE])) begin
        nxt_st.gpr_abort = 1'b1;
      end
    end else if (!st_ff.cmd[`WGR_CMD_REMOTE]) begin
      // Local operator owns polarity while remote control is off
      if (i_local_rev_set) begin
        nxt_st.rev_pol = 1'b1;
      end else if (i_local_rev_clr) begin
        nxt_st.rev_pol = 1'b0;
      end
    end

    // Guide point offset, honoured only with bit 13 set
    if (ofs_wr) begin
      nxt_st.offset = i_wr_data;
      if (st_ff.cmd[`WGR_CMD_OFS_EN]) begin
        nxt_st.gp_ld  = 1'b1;
        nxt_st.gp_tgt = $signed(i_wr_data);
      end
    end

    // Accepted guide-point reset adopts the web position
    if (tmr_accept) begin
      nxt_st.gp_ld  = 1'b1;
      nxt_st.gp_tgt = i_web_pos;
    end

    // Actuator speed from the upper field
    if (spd_wr) begin
      nxt_st.speed_reg = i_wr_data;
      if (i_wr_data[`WGR_SPD_EN]) begin
        nxt_st.speed = sat_param(i_wr_data[`WGR_SPD_MSB:`WGR_SPD_LSB]);
      end
    end

    // Actuator acceleration from the lower field
    if (acc_wr) begin
      nxt_st.accel_reg = i_wr_data;
      if (i_wr_data[`WGR_ACC_EN]) begin
        nxt_st.accel = sat_param(i_wr_data[6:0]);
      end
    end

    // Application page: only the two defined pages are taken
    if (page_wr) begin
      if (i_wr_data == `WGR_PAGE_DEFAULT) begin
        nxt_st.page       = i_wr_data;
        nxt_st.web_map    = 1'b0;
        nxt_st.page_flags = 2'b00;
      end else if (i_wr_data == `WGR_PAGE_WEB) begin
        nxt_st.page       = i_wr_data;
        nxt_st.web_map    = 1'b1;
        nxt_st.page_flags = 2'b11;
      end
    end

    // Read-back mux, command word is write-only
    unique case (i_rd_index)
      `WGR_IDX_OFFSET: nxt_st.rd_data = st_ff.offset;
      `WGR_IDX_SPEED:  nxt_st.rd_data = st_ff.speed_reg;
      `WGR_IDX_ACCEL:  nxt_st.rd_data = st_ff.accel_reg;
      `WGR_IDX_PAGE:   nxt_st.rd_data = st_ff.page;
      default:         nxt_st.rd_data = `WGR_REG_RESET;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  // Reset leaves polarity standard and all triggers cleared
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else if (i_ce) begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // Sub-blocks
  // ****************************************
  // Guide-point reset timeout
  wgr_gpr_timer #(
    .TIMEOUT_CYC (GPR_TIMEOUT_CYC)
  ) u_timer (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_start   (st_ff.gpr_start),
    .i_release (st_ff.gpr_release),
    .i_abort   (st_ff.gpr_abort),
    .o_accept  (tmr_accept),
    .o_reject  (tmr_reject),
    .o_busy    (tmr_busy)
  );

  // Guide point clamp and scaling
  wgr_gp_calc u_gp (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_ce       (i_ce),
    .i_load     (st_ff.gp_ld),
    .i_target   (st_ff.gp_tgt),
    .i_win_half (i_win_half),
    .o_gp       (o_guide_point),
    .o_gp_nm    (o_guide_point_nm)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign o_rd_data      = st_ff.rd_data;
  assign o_remote_ctrl  = st_ff.cmd[`WGR_CMD_REMOTE];
  assign o_auto_mode    = st_ff.cmd[`WGR_CMD_AUTO];
  assign o_center_start = st_ff.center;
  assign o_rev_polarity = st_ff.rev_pol;
  assign o_gpr_busy     = tmr_busy;
  assign o_gpr_accept   = tmr_accept;
  assign o_gpr_reject   = tmr_reject;
  assign o_speed        = st_ff.speed;
  assign o_accel        = st_ff.accel;
  assign o_web_map      = st_ff.web_map;
  assign o_page_flags   = st_ff.page_flags;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_center_manual;
    i_ce && rise_center && !i_wr_data[`WGR_CMD_AUTO];
  endsequence

  sequence s_center_auto;
    i_ce && rise_center && i_wr_data[`WGR_CMD_AUTO];
  endsequence

  sequence s_gpr_armed;
    i_ce && rise_gpr && !i_wr_data[`WGR_CMD_AUTO] && i_wr_data[`WGR_CMD_REMOTE] && !tmr_busy;
  endsequence

  a_center_pulse: assert property (s_center_manual |=> o_center_start)
    else $error("Centering not started");

  a_center_gate: assert property (o_center_start |-> !o_auto_mode ##1 !o_center_start)
    else $error("Centering in wrong mode or held");

  a_mid_point: assert property (s_center_auto |=> st_ff.gp_ld && st_ff.gp_tgt == 16'sh0)
    else $error("Auto trigger did not target midpoint");

  a_offset_gate: assert property ((i_ce && ofs_wr && !tmr_accept) |=>
      (st_ff.gp_ld == $past(st_ff.cmd[`WGR_CMD_OFS_EN])))
    else $error("Offset write gate wrong");

  a_gpr_gate: assert property ((i_ce && st_ff.gpr_start) |-> !o_auto_mode && o_remote_ctrl)
    else $error("Reset routine started without remote manual");

  a_gpr_arm: assert property (s_gpr_armed ##1 i_ce ##1 1'b1 |-> o_gpr_busy)
    else $error("Reset routine not armed");

  a_gpr_adopt: assert property ((i_ce && tmr_accept) |=> st_ff.gp_ld && st_ff.gp_tgt == $past(i_web_pos))
    else $error("Accepted reset did not adopt web position");

  a_polarity: assert property ((i_ce && cmd_wr) |=> o_rev_polarity == $past(i_wr_data[`WGR_CMD_REV_POL]))
    else $error("Polarity does not follow bit 15");

  a_speed_hold: assert property ((i_ce && spd_wr && !i_wr_data[`WGR_SPD_EN]) |=> $stable(o_speed))
    else $error("Speed changed without enable");

  a_accel_hold: assert property ((i_ce && acc_wr && !i_wr_data[`WGR_ACC_EN]) |=> $stable(o_accel))
    else $error("Acceleration changed without enable");

  a_page_flags: assert property (o_page_flags == {2{o_web_map}})
    else $error("Page flags disagree with map");

  // Triggers
  a_center_zero: assert property ((i_ce && cmd_wr && !i_wr_data[`WGR_CMD_CENTER]) |=>
      !o_center_start)
    else $error("Zero bit 12 started centering");

  a_center_hold: assert property ((i_ce && cmd_wr && st_ff.cmd[`WGR_CMD_CENTER]) |=>
      !o_center_start)
    else $error("Held bit 12 acted again");

  a_gp_hold: assert property ((i_ce && !st_ff.gp_ld) |=>
      $stable(o_guide_point))
    else $error("Guide point moved unloaded");

  // Mode bits
  a_remote_bit: assert property ((i_ce && cmd_wr) |=>
      o_remote_ctrl == $past(i_wr_data[`WGR_CMD_REMOTE]))
    else $error("Remote bit not taken");

  a_auto_bit: assert property ((i_ce && cmd_wr) |=>
      o_auto_mode == $past(i_wr_data[`WGR_CMD_AUTO]))
    else $error("Mode bit not taken");

  a_local_lock: assert property ((i_ce && !cmd_wr && o_remote_ctrl) |=>
      $stable(o_rev_polarity))
    else $error("Local polarity under remote");

  // Parameters
  a_param_max: assert property ((o_speed <= `WGR_PARAM_MAX) &&
      (o_accel <= `WGR_PARAM_MAX))
    else $error("Actuator parameter above 100");

  a_speed_take: assert property ((i_ce && spd_wr && i_wr_data[`WGR_SPD_EN] &&
      i_wr_data[`WGR_SPD_MSB:`WGR_SPD_LSB] <= `WGR_PARAM_MAX) |=> o_speed == $past(i_wr_data[`WGR_SPD_MSB:`WGR_SPD_LSB]))
    else $error("Enabled speed not taken");

  a_accel_take: assert property ((i_ce && acc_wr && i_wr_data[`WGR_ACC_EN] &&
      i_wr_data[6:0] <= `WGR_PARAM_MAX) |=> o_accel == $past(i_wr_data[6:0]))
    else $error("Enabled acceleration not taken");

  // Pages
  a_page_keep: assert property ((i_ce && page_wr && i_wr_data > `WGR_PAGE_WEB) |=>
      $stable(o_web_map) && $stable(o_page_flags))
    else $error("Undefined page changed map");

  a_page_web: assert property ((i_ce && page_wr && i_wr_data == `WGR_PAGE_WEB) |=>
      o_web_map && o_page_flags == 2'b11)
    else $error("Page one not confirmed");

  // Reset routine
  sequence s_gpr_lost;
    i_ce && tmr_busy && !st_ff.gpr_release && cmd_wr && (i_wr_data[`WGR_CMD_AUTO] || !i_wr_data[`WGR_CMD_REMOTE]);
  endsequence

  a_gpr_lost: assert property (s_gpr_lost |=>
      o_gpr_reject or (i_ce ##1 o_gpr_reject))
    else $error("Lost control did not reject");

  a_gpr_outcome: assert property (o_gpr_accept |->
      !o_gpr_reject)
    else $error("Reset both accepted and rejected");
endmodule

// [dv/wgr_plc_model.sv]
`timescale 1ns/1ps
// ****************************************
// Fieldbus master model
// ****************************************
module wgr_plc_model (
  // Clock
  input  wire logic        i_clk,
  // Word write and read select
  output logic             o_wr_en,
  output logic      [2:0]  o_wr_index,
  output logic      [15:0] o_wr_data,
  output logic      [2:0]  o_rd_index
);
  logic [15:0] last_cmd;

  // Idle bus at time zero
  initial begin
    o_wr_en    = 1'b0;
    o_wr_index = 3'h7;
    o_wr_data  = 16'hffff;
    o_rd_index = 3'h7;
    last_cmd   = 16'h0000;
  end

  // One-cycle strobe; released lines carry the inverse so stale data is never seen
  task automatic wr_word(input logic [2:0] idx, input logic [15:0] d);
    @(negedge i_clk);
    o_wr_en    = 1'b1;
    o_wr_index = idx;
    o_wr_data  = d;
    if (idx == 3'h0)
      last_cmd = d;
    @(negedge i_clk);
    o_wr_en    = 1'b0;
    o_wr_index = ~idx;
    o_wr_data  = ~d;
  endtask

  // Command write; a held centering bit 12 is lowered first so it can act again
  task automatic cmd(input logic [15:0] d);
    if (last_cmd[12] && d[12])
      wr_word(3'h0, last_cmd & 16'hefff);
    wr_word(3'h0, d);
  endtask

  // Read select, a level
  task automatic rd_sel(input logic [2:0] idx);
    @(negedge i_clk);
    o_rd_index = idx;
  endtask
endmodule

// [dv/wgr_cmd_regs_test.sv]
`timescale 1ns/1ps
// ****************************************
// Command register bench
// ****************************************
module wgr_cmd_regs_test;
  typedef struct {int s; logic [31:0] v;} wgr_note_t;
  localparam logic [15:0] WIN    = 16'h0200;
  localparam int          MARGIN = 3175000 / 63500;
  logic               i_clk, i_rst_n, i_ce, i_local_rev_set, i_local_rev_clr;
  logic               wr_en, o_remote_ctrl, o_auto_mode, o_center_start, o_rev_polarity;
  logic               o_gpr_busy, o_gpr_accept, o_gpr_reject, o_web_map;
  logic        [2:0]  wr_index, rd_index;
  logic        [15:0] wr_data, o_rd_data;
  logic signed [15:0] i_web_pos, o_guide_point;
  logic signed [31:0] o_guide_point_nm;
  logic        [6:0]  o_speed, o_accel;
  logic        [1:0]  o_page_flags;
  logic        [31:0] ob[14];
  int                 n_fail, tests_run, n_ctr, n_acc, n_rej;
  wgr_note_t          notes[$];
  event               smp;
  string              what[14] = '{"center", "polarity", "gp", "gp_nm", "busy", "accept", "reject",
                                   "speed", "accel", "web_map", "flags", "rd_data", "auto", "remote"};

  // Clock
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  wgr_cmd_regs #(.GPR_TIMEOUT_CYC(32'h0000_0014)) dut_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_wr_en(wr_en), .i_wr_index(wr_index), .i_wr_data(wr_data),
    .i_rd_index(rd_index), .o_rd_data(o_rd_data),
    .i_local_rev_set(i_local_rev_set), .i_local_rev_clr(i_local_rev_clr), .i_web_pos(i_web_pos), .i_win_half(WIN),
    .o_remote_ctrl(o_remote_ctrl), .o_auto_mode(o_auto_mode), .o_center_start(o_center_start),
    .o_rev_polarity(o_rev_polarity), .o_guide_point(o_guide_point), .o_guide_point_nm(o_guide_point_nm),
    .o_gpr_busy(o_gpr_busy), .o_gpr_accept(o_gpr_accept), .o_gpr_reject(o_gpr_reject),
    .o_speed(o_speed), .o_accel(o_accel), .o_web_map(o_web_map), .o_page_flags(o_page_flags)
  );
  wgr_plc_model plc_u (
    .i_clk(i_clk), .o_wr_en(wr_en), .o_wr_index(wr_index), .o_wr_data(wr_data), .o_rd_index(rd_index)
  );

  // ****************************************
  // Observation and comparison
  // ****************************************
  // Pulses are counted so their number, not their exact cycle, is compared
  always @(posedge i_clk) begin
    n_ctr <= n_ctr + int'(o_center_start === 1'b1);
    n_acc <= n_acc + int'(o_gpr_accept === 1'b1);
    n_rej <= n_rej + int'(o_gpr_reject === 1'b1);
  end
  always_comb ob = '{32'(n_ctr), 32'(o_rev_polarity), {16'h0000, o_guide_point}, o_guide_point_nm,
                     32'(o_gpr_busy), 32'(n_acc), 32'(n_rej), 32'(o_speed), 32'(o_accel),
                     32'(o_web_map), 32'(o_page_flags), {16'h0000, o_rd_data}, 32'(o_auto_mode),
                     32'(o_remote_ctrl)};

  // All pending notes are compared, oldest first, whenever results are due
  always @(smp) begin
    while (notes.size() > 0) begin
      check(what[notes[0].s], ob[notes[0].s], notes[0].v);
      void'(notes.pop_front());
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Write a word, select it for reading, note expectations, compare once settled
  task automatic step(input logic [2:0] wi, input logic [15:0] wd, input int s1, input logic [31:0] v1,
                      input int s2 = -1, input logic [31:0] v2 = 32'h0, input logic [31:0] v3 = 32'hffffffff);
    if (wi == 3'h0)
      plc_u.cmd(wd);
    else
      plc_u.wr_word(wi, wd);
    plc_u.rd_sel(wi);
    notes.push_back('{s1, v1});
    if (s2 >= 0)
      notes.push_back('{s2, v2});
    if (v3 !== 32'hffffffff)
      notes.push_back('{11, v3});
    repeat (3) @(negedge i_clk);
    -> smp;
    #1;
  endtask

  // Bounded wait for an observed value
  task automatic wait_for(input int s, input logic [31:0] v);
    int k;
    for (k = 0; k < 60 && ob[s] !== v; k++)
      @(negedge i_clk);
    if (k == 60) begin
      n_fail++;
      print_verdict();
    end
  endtask

  // Expected guide point keeps the travel margin free on both sides
  function automatic logic [15:0] clampv(input logic signed [15:0] x);
    logic signed [16:0] lim;
    lim = $signed({1'b0, WIN}) - 17'(MARGIN);
    if ($signed({x[15], x}) > lim)
      return 16'(lim);
    if ($signed({x[15], x}) < -lim)
      return 16'(-lim);
    return x;
  endfunction

  function automatic logic [31:0] nmv(input logic signed [15:0] g);
    return 32'(32'(g) * 63500);
  endfunction

  task automatic do_reset();
    @(negedge i_clk);
    i_rst_n = 1'b0;
    repeat (16) @(negedge i_clk);
    i_rst_n = 1'b1;
  endtask

  task automatic pulse_set(input logic clr = 1'b0);
    @(negedge i_clk);
    i_local_rev_set = !clr;
    i_local_rev_clr = clr;
    @(negedge i_clk);
    i_local_rev_set = 1'b0;
    i_local_rev_clr = 1'b0;
  endtask

  // Hang guard
  initial begin
    #5000000;
    n_fail++;
    print_verdict();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    logic [15:0] ov[6];
    logic [2:0]  ti[6];
    logic [15:0] td[6];
    logic [6:0]  ts[6];
    logic [6:0]  ta[6];
    int          i;
    i_rst_n         = 1'b0;
    i_ce            = 1'b1;
    i_local_rev_set = 1'b0;
    i_local_rev_clr = 1'b0;
    i_web_pos       = 16'sh0000;
    void'($urandom(62));
    do_reset();
    step(3'h7, 16'h0000, 1, 32'h0, 2, 32'h0, 32'h0);
    step(3'h0, 16'h1000, 0, 32'h1);
    plc_u.wr_word(3'h0, 16'h1000);
    step(3'h7, 16'h0000, 0, 32'h1);
    step(3'h0, 16'h1000, 0, 32'h2);
    step(3'h0, 16'h0000, 0, 32'h2, -1, 32'h0, 32'h0);
    step(3'h0, 16'h0300, 12, 32'h1, 13, 32'h1);
    ov = '{16'h0000, 16'h01ce, 16'h01cf, 16'hfe31, 16'h8000, 16'h7fff};
    ov[0] = 16'($urandom_range(1200)) - 16'h0258;
    step(3'h0, 16'h2000, 12, 32'h0, 13, 32'h0);
    for (i = 0; i < 6; i++) begin
      step(3'h1, ov[i], 2, {16'h0000, clampv(ov[i])}, 3, nmv(clampv(ov[i])), {16'h0000, ov[i]});
    end
    step(3'h0, 16'h0000, 9, 32'h0);
    step(3'h1, 16'h0010, 2, {16'h0000, clampv(16'h7fff)});
    step(3'h0, 16'h1200, 2, 32'h0, 0, 32'h2);
    step(3'h0, 16'h8000, 1, 32'h1);
    step(3'h0, 16'h0000, 1, 32'h0);
    pulse_set();
    step(3'h7, 16'h0000, 1, 32'h1);
    pulse_set(1'b1);
    step(3'h7, 16'h0000, 1, 32'h0);
    pulse_set();
    do_reset();
    step(3'h7, 16'h0000, 1, 32'h0, 2, 32'h0);
    step(3'h0, 16'h0100, 13, 32'h1);
    pulse_set();
    step(3'h7, 16'h0000, 1, 32'h0);
    // Speed and acceleration table, enabled and ignored writes
    ti = '{3'h2, 3'h2, 3'h3, 3'h3, 3'h2, 3'h3};
    td = '{16'hb200, 16'h3000, 16'h00b2, 16'h0030, 16'h0000, 16'h0000};
    ts = '{7'h32, 7'h32, 7'h32, 7'h32, 7'h00, 7'h00};
    ta = '{7'h00, 7'h00, 7'h32, 7'h32, 7'h32, 7'h00};
    ts[4] = 7'($urandom_range(100));
    ts[5] = ts[4];
    ta[5] = 7'($urandom_range(100));
    td[4] = {1'b1, ts[4], 8'h00};
    td[5] = {8'h00, 1'b1, ta[5]};
    for (i = 0; i < 6; i++) begin
      step(ti[i], td[i], 7, 32'(ts[i]), 8, 32'(ta[i]), 32'(td[i]));
    end
    step(3'h2, 16'hff00, 7, 32'h64);
    step(3'h4, 16'h0001, 9, 32'h1, 10, 32'h3, 32'h1);
    step(3'h4, 16'h0005, 9, 32'h1, 10, 32'h3);
    step(3'h4, 16'h0000, 9, 32'h0);
    step(3'h7, 16'h1234, 9, 32'h0, -1, 32'h0, 32'h0);
    // Guide-point reset: accepted, timed out, refused
    @(negedge i_clk);
    i_web_pos = 16'($urandom_range(800)) - 16'sh0190;
    ov[0] = clampv(i_web_pos);
    step(3'h0, 16'h4100, 5, 32'h0);
    wait_for(4, 32'h1);
    step(3'h0, 16'h0100, 5, 32'h1, 4, 32'h0);
    step(3'h7, 16'h0000, 2, {16'h0000, ov[0]});
    @(negedge i_clk);
    i_web_pos = ~i_web_pos;
    step(3'h0, 16'h4100, 6, 32'h0);
    wait_for(6, 32'h1);
    step(3'h0, 16'h0100, 5, 32'h1, 2, {16'h0000, ov[0]});
    step(3'h0, 16'h4300, 4, 32'h0, 6, 32'h1);
    step(3'h0, 16'h0000, 4, 32'h0);
    step(3'h0, 16'h4100, 4, 32'h1);
    step(3'h0, 16'h0300, 6, 32'h2, 4, 32'h0);
    step(3'h0, 16'h4000, 4, 32'h0, 6, 32'h2);
    // Frozen while the clock enable is low
    @(negedge i_clk);
    i_ce = 1'b0;
    step(3'h0, 16'h8000, 1, 32'h0);
    print_verdict();
  end
endmodule
